// [rtl/esc_pkg.sv]
// Package with constants and decode helpers for the enable and strap configuration block
// Operation
// - Pre-ramp delay 2ms precise, up to 4ms normal
// - Precise timing only for pin enable
// - Self-enabled device drops precise timing
// - Normal mode turn-off response up to 4ms
// - Clamp duty to off-time limit, max 95%
// - Strap pins classed low, open, high, resistor
// - Sample straps only at power-up or restore
// - Three strap settings or 31 resistor selections
// - Address and limit pin-only; rest bus-writable
// - Bus address from address strap pin
// - Output limit is strap voltage plus 10%
// - User configuration kept in retained store
// - Preset thresholds raise alerts to host
// - Memory check 5-10ms ignores enable, bus
// - Load store, then straps, then ready
`default_nettype none
package esc_pkg;
  // Register bus
  localparam int ESC_ADDR_W = 4;
  localparam int ESC_DATA_W = 16;
  localparam logic [3:0] ESC_REG_CTRL = 4'h0;
  localparam logic [3:0] ESC_REG_STATUS = 4'h1;
  localparam logic [3:0] ESC_REG_IRQ_STAT = 4'h2;
  localparam logic [3:0] ESC_REG_IRQ_MASK = 4'h3;
  localparam logic [3:0] ESC_REG_VOUT = 4'h4;
  localparam logic [3:0] ESC_REG_LIMIT = 4'h5;
  localparam logic [3:0] ESC_REG_BUS_ID = 4'h6;
  localparam logic [3:0] ESC_REG_FSW = 4'h7;
  localparam logic [3:0] ESC_REG_DUTY_MAX = 4'h8;
  localparam logic [3:0] ESC_REG_THRESH = 4'h9;
  // Control bits
  localparam int ESC_CTRL_BUS_ON = 0;
  localparam int ESC_CTRL_PRECISE = 1;
  localparam int ESC_CTRL_RESTORE = 2;
  localparam int ESC_CTRL_SAVE = 3;
  // Interrupt bits
  localparam int ESC_IRQ_READY = 0;
  localparam int ESC_IRQ_RAMP_ON = 1;
  localparam int ESC_IRQ_RAMP_OFF = 2;
  localparam int ESC_IRQ_ALERT = 3;
  // Reset values
  localparam logic [1:0] ESC_CTRL_RST = 2'h2;
  localparam logic [15:0] ESC_FSW_RST = 16'h0190;
  localparam logic [15:0] ESC_THRESH_RST = 16'hFFFF;
  localparam logic [3:0] ESC_MASK_RST = 4'h0;
  // Timing
  localparam int ESC_CLK_HZ = 20_000_000;
  localparam int ESC_PRE_PRECISE_MS = 2;
  localparam int ESC_PRE_NORMAL_MS = 4;
  localparam int ESC_OFF_NORMAL_MS = 4;
  localparam int ESC_MEMCHK_MS = 5;
  localparam int ESC_PRE_PRECISE_CYC = ESC_PRE_PRECISE_MS * (ESC_CLK_HZ / 1000);
  localparam int ESC_PRE_NORMAL_CYC = ESC_PRE_NORMAL_MS * (ESC_CLK_HZ / 1000);
  localparam int ESC_OFF_NORMAL_CYC = ESC_OFF_NORMAL_MS * (ESC_CLK_HZ / 1000);
  localparam int ESC_MEMCHK_CYC = ESC_MEMCHK_MS * (ESC_CLK_HZ / 1000);
  // Duty limit in per-mille
  localparam int ESC_MIN_OFF_NS = 150;
  localparam int ESC_DUTY_FULL = 1000;
  localparam int ESC_DUTY_CAP = 950;
  // Strap classes
  localparam logic [1:0] ESC_KIND_LOW = 2'h0;
  localparam logic [1:0] ESC_KIND_OPEN = 2'h1;
  localparam logic [1:0] ESC_KIND_HIGH = 2'h2;
  localparam logic [1:0] ESC_KIND_RES = 2'h3;
  localparam int ESC_RES_LAST = 30;
  // Strap voltages in mV
  localparam logic [15:0] ESC_LOW_MV = 16'h04B0;
  localparam logic [15:0] ESC_OPEN_MV = 16'h05DC;
  localparam logic [15:0] ESC_HIGH_MV = 16'h0CE4;
  localparam logic [15:0] ESC_RES_MV [0:30] = '{
    16'h0258, 16'h02BC, 16'h02EE, 16'h0320, 16'h0384, 16'h03E8, 16'h044C, 16'h04B0,
    16'h04E2, 16'h0514, 16'h0578, 16'h05DC, 16'h0640, 16'h06A4, 16'h0708, 16'h076C,
    16'h07D0, 16'h0834, 16'h0898, 16'h08FC, 16'h0960, 16'h09C4, 16'h0A28, 16'h0A8C,
    16'h0AF0, 16'h0B54, 16'h0BB8, 16'h0C1C, 16'h0C80, 16'h0CE4, 16'h1388};
  localparam int ESC_LIMIT_NUM = 11;
  localparam int ESC_LIMIT_DEN = 10;
  // Bus id base, arbitrary value
  localparam logic [6:0] ESC_BUS_ID_BASE = 7'h20;
  // Retained store layout
  localparam logic [15:0] ESC_STORE_MARK = 16'hA5C3;
  localparam logic [2:0] ESC_SW_MARK = 3'h0;
  localparam logic [2:0] ESC_SW_VOUT = 3'h1;
  localparam logic [2:0] ESC_SW_FSW = 3'h2;
  localparam logic [2:0] ESC_SW_CTRL = 3'h3;
  localparam logic [2:0] ESC_SW_THRESH = 3'h4;

  // Strap code to output voltage
  function automatic logic [15:0] esc_vout_mv(input logic [6:0] s);
    logic [15:0] mv;
    mv = ESC_LOW_MV;
    case (s[6:5])
      ESC_KIND_LOW: mv = ESC_LOW_MV;
      ESC_KIND_OPEN: mv = ESC_OPEN_MV;
      ESC_KIND_HIGH: mv = ESC_HIGH_MV;
      ESC_KIND_RES: mv = (int'(s[4:0]) > ESC_RES_LAST) ? ESC_RES_MV[ESC_RES_LAST] : ESC_RES_MV[s[4:0]];
    endcase
    return mv;
  endfunction

  // Strap code to bus address
  function automatic logic [6:0] esc_bus_id(input logic [6:0] s, input logic [6:0] base);
    logic [6:0] off;
    off = (s[6:5] == ESC_KIND_RES) ? 7'(7'h03 + {2'h0, s[4:0]}) : {5'h00, s[6:5]};
    return 7'(base + off);
  endfunction

  // Max duty per-mille from switching frequency in kHz
  function automatic logic [9:0] esc_duty_max(input logic [15:0] fsw_khz);
    int off;
    int dmax;
    off = (int'(fsw_khz) * ESC_MIN_OFF_NS + 999) / 1000;
    dmax = (off >= ESC_DUTY_FULL) ? 0 : ESC_DUTY_FULL - off;
    if (dmax > ESC_DUTY_CAP)
      dmax = ESC_DUTY_CAP;
    return 10'(dmax);
  endfunction
endpackage
`default_nettype wire

// [rtl/esc_store.sv]
// Retained configuration store with registered read port
`timescale 1ns/1ps
`default_nettype none
module esc_store #(
  parameter int W = 16,
  parameter int D = 8,
  parameter int AW = 3
)(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  // Array has no reset so contents survive
  logic [W-1:0] mem [0:D-1];

  // Write port
  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // Registered read port
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      rd_data <= '0;
    else
      rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// [rtl/esc_top.sv]
// Configuration loader, enable sequencer and duty clamp
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module esc_top
  import esc_pkg::*;
#(
  parameter int PRE_PRECISE_CYC = ESC_PRE_PRECISE_CYC,
  parameter int PRE_NORMAL_CYC = ESC_PRE_NORMAL_CYC,
  parameter int OFF_NORMAL_CYC = ESC_OFF_NORMAL_CYC,
  parameter int MEMCHK_CYC = ESC_MEMCHK_CYC,
  parameter logic [6:0] BUS_ID_BASE = ESC_BUS_ID_BASE
)(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic en_pin,
  input wire logic [6:0] bus_id_strap_pin,
  input wire logic [6:0] output_level_strap,
  input wire logic [15:0] mon_value,
  input wire logic [9:0] duty_req,
  output logic [9:0] duty_out,
  output logic ramp_go,
  output logic cfg_ready,
  output logic [6:0] bus_id,
  output logic [15:0] output_upper_limit,
  output logic [15:0] vout_set,
  output logic irq
);
  // Counter end values
  localparam logic [19:0] PRE_P_END = 20'(PRE_PRECISE_CYC - 1);
  localparam logic [19:0] PRE_N_END = 20'(PRE_NORMAL_CYC - 1);
  localparam logic [19:0] OFF_N_END = 20'(OFF_NORMAL_CYC - 1);
  localparam logic [19:0] CHK_END = 20'(MEMCHK_CYC - 1);
  localparam logic [2:0] SW_END = 3'(ESC_SW_THRESH + 3'h1);

  typedef enum logic [2:0] {LD_CHECK, LD_READ, LD_PINS, LD_READY, LD_SAVE} esc_ld_t;
  typedef enum logic [1:0] {SQ_OFF, SQ_PRE, SQ_ON, SQ_POST} esc_sq_t;

  // Pin synchroniser stages
  logic [14:0] sy1_reg;
  logic [14:0] sy2_reg;
  logic [14:0] sy3_reg;
  logic [14:0] pin_reg;
  // Loader state
  esc_ld_t ld_st_reg;
  logic [19:0] ld_cnt_reg;
  logic [2:0] ld_idx_reg;
  logic mark_ok_reg;
  logic vout_st_reg;
  // Configuration
  logic [1:0] ctl_reg;
  logic [15:0] vout_reg;
  logic [15:0] fsw_reg;
  logic [15:0] thresh_reg;
  logic [3:0] mask_reg;
  logic [3:0] stat_reg;
  logic [15:0] pin_mv_reg;
  logic self_en_reg;
  // Sequencer
  esc_sq_t sq_st_reg;
  logic [19:0] sq_cnt_reg;
  logic precise_run_reg;
  logic [9:0] duty_max_reg;
  // Store port
  logic [15:0] st_rdata;
  logic [15:0] st_wdata;
  // Decoded terms
  logic ready;
  logic wr_ok;
  logic ctl_wr;
  logic en_req;
  logic pre_done;
  logic post_done;
  logic [3:0] stat_set;
  logic [3:0] stat_clr;
  logic [15:0] rd_mux;

  // Bus writes accepted only once ready
  assign ready = (ld_st_reg == LD_READY);
  assign wr_ok = reg_wr && ready;
  assign ctl_wr = wr_ok && (reg_addr == ESC_REG_CTRL);
  // Pin level or bus bit requests the output
  assign en_req = pin_reg[14] | ctl_reg[ESC_CTRL_BUS_ON];
  assign pre_done = sq_cnt_reg == (precise_run_reg ? PRE_P_END : PRE_N_END);
  assign post_done = precise_run_reg || (sq_cnt_reg == OFF_N_END);

  // Three-stage sync of enable and straps
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sy1_reg <= '0;
      sy2_reg <= '0;
      sy3_reg <= '0;
    end
    else
    begin
      sy1_reg <= {en_pin, bus_id_strap_pin, output_level_strap};
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      pin_reg <= '0;
    else if (sy2_reg == sy3_reg)
      pin_reg <= sy3_reg;
  end

  // Load sequence: check, read store, straps, ready
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      ld_st_reg <= LD_CHECK;
      ld_cnt_reg <= '0;
      ld_idx_reg <= '0;
    end
    else
    begin
      unique case (ld_st_reg)
        LD_CHECK:
        begin
          // Memory check time, enable and bus ignored
          if (ld_cnt_reg == CHK_END)
          begin
            ld_st_reg <= LD_READ;
            ld_idx_reg <= '0;
          end
          ld_cnt_reg <= (ld_cnt_reg == CHK_END) ? '0 : 20'(ld_cnt_reg + 20'h00001);
        end
        LD_READ:
        begin
          // Store words first, straps after
          if (ld_idx_reg == SW_END)
            ld_st_reg <= LD_PINS;
          else
            ld_idx_reg <= 3'(ld_idx_reg + 3'h1);
        end
        LD_PINS:
          ld_st_reg <= LD_READY;
        LD_READY:
        begin
          // Restore reruns the whole load
          if (ctl_wr && reg_wdata[ESC_CTRL_RESTORE])
          begin
            ld_st_reg <= LD_CHECK;
            ld_cnt_reg <= '0;
          end
          else if (ctl_wr && reg_wdata[ESC_CTRL_SAVE])
          begin
            ld_st_reg <= LD_SAVE;
            ld_idx_reg <= '0;
          end
        end
        LD_SAVE:
        begin
          // One word per cycle into the store
          if (ld_idx_reg == ESC_SW_THRESH)
            ld_st_reg <= LD_READY;
          else
            ld_idx_reg <= 3'(ld_idx_reg + 3'h1);
        end
      endcase
    end
  end

  // Save data selection
  always_comb
  begin
    case (ld_idx_reg)
      ESC_SW_MARK: st_wdata = ESC_STORE_MARK;
      ESC_SW_VOUT: st_wdata = vout_reg;
      ESC_SW_FSW: st_wdata = fsw_reg;
      ESC_SW_CTRL: st_wdata = {14'h0000, ctl_reg};
      default: st_wdata = thresh_reg;
    endcase
  end

  // Retained store
  esc_store #(.W(16), .D(8), .AW(3)) u_store (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_en(ld_st_reg == LD_SAVE),
    .wr_addr(ld_idx_reg),
    .wr_data(st_wdata),
    .rd_addr(ld_idx_reg),
    .rd_data(st_rdata)
  );

  // Stored values, then strap values, then bus writes
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      mark_ok_reg <= 1'b0;
      vout_st_reg <= 1'b0;
      ctl_reg <= ESC_CTRL_RST;
      vout_reg <= '0;
      fsw_reg <= ESC_FSW_RST;
      thresh_reg <= ESC_THRESH_RST;
    end
    else if (ld_st_reg == LD_CHECK)
      vout_st_reg <= 1'b0;
    else if (ld_st_reg == LD_READ && ld_idx_reg != 3'h0)
    begin
      // Word arrives one cycle after its address
      unique case (3'(ld_idx_reg - 3'h1))
        ESC_SW_MARK:
          mark_ok_reg <= (st_rdata == ESC_STORE_MARK) ? 1'b1 : 1'b0;
        ESC_SW_VOUT:
          if (mark_ok_reg)
          begin
            vout_reg <= st_rdata;
            vout_st_reg <= 1'b1;
          end
        ESC_SW_FSW:
          if (mark_ok_reg)
            fsw_reg <= st_rdata;
        ESC_SW_CTRL:
          if (mark_ok_reg)
            ctl_reg <= st_rdata[1:0];
        default:
          if (mark_ok_reg)
            thresh_reg <= st_rdata;
      endcase
    end
    else if (ld_st_reg == LD_PINS && !vout_st_reg)
      vout_reg <= esc_vout_mv(pin_reg[6:0]);
    else if (wr_ok)
    begin
      // Bus may overwrite pin-set values
      case (reg_addr)
        ESC_REG_CTRL: ctl_reg <= reg_wdata[1:0];
        ESC_REG_VOUT: vout_reg <= reg_wdata;
        ESC_REG_FSW: fsw_reg <= reg_wdata;
        ESC_REG_THRESH: thresh_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Pin-only settings captured once per load
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      bus_id <= '0;
      pin_mv_reg <= '0;
      output_upper_limit <= '0;
      self_en_reg <= 1'b0;
    end
    else if (ld_st_reg == LD_PINS)
    begin
      bus_id <= esc_bus_id(pin_reg[13:7], BUS_ID_BASE);
      pin_mv_reg <= esc_vout_mv(pin_reg[6:0]);
      output_upper_limit <= 16'((32'(esc_vout_mv(pin_reg[6:0])) * ESC_LIMIT_NUM) / ESC_LIMIT_DEN);
      self_en_reg <= pin_reg[14];
    end
  end

  // Enable sequencer
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sq_st_reg <= SQ_OFF;
      sq_cnt_reg <= '0;
      precise_run_reg <= 1'b0;
      ramp_go <= 1'b0;
    end
    else
    begin
      unique case (sq_st_reg)
        SQ_OFF:
          if (en_req && ready)
          begin
            sq_st_reg <= SQ_PRE;
            sq_cnt_reg <= '0;
            // Precise only from the pin, not self-enabled
            precise_run_reg <= ctl_reg[ESC_CTRL_PRECISE] && pin_reg[14] &&
                               !ctl_reg[ESC_CTRL_BUS_ON] && !self_en_reg;
          end
        SQ_PRE:
          if (!en_req)
            sq_st_reg <= SQ_OFF;
          else if (pre_done)
          begin
            sq_st_reg <= SQ_ON;
            ramp_go <= 1'b1;
          end
          else
            sq_cnt_reg <= 20'(sq_cnt_reg + 20'h00001);
        SQ_ON:
          if (!en_req)
          begin
            sq_st_reg <= SQ_POST;
            sq_cnt_reg <= '0;
          end
        SQ_POST:
          if (post_done)
          begin
            sq_st_reg <= SQ_OFF;
            ramp_go <= 1'b0;
          end
          else
            sq_cnt_reg <= 20'(sq_cnt_reg + 20'h00001);
      endcase
    end
  end

  // Duty clamp, zero while not ramping
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      duty_max_reg <= '0;
      duty_out <= '0;
    end
    else
    begin
      duty_max_reg <= esc_duty_max(fsw_reg);
      // Also zero on the edge that drops ramp_go, so no stale duty lingers
      if (!ramp_go || stat_set[ESC_IRQ_RAMP_OFF])
        duty_out <= '0;
      else
        duty_out <= (duty_req > duty_max_reg) ? duty_max_reg : duty_req;
    end
  end

  // Event sources and write-one clears
  assign stat_set[ESC_IRQ_READY] = (ld_st_reg == LD_PINS);
  assign stat_set[ESC_IRQ_RAMP_ON] = (sq_st_reg == SQ_PRE) && en_req && pre_done;
  assign stat_set[ESC_IRQ_RAMP_OFF] = (sq_st_reg == SQ_POST) && post_done;
  assign stat_set[ESC_IRQ_ALERT] = ready && (mon_value > thresh_reg);
  assign stat_clr = (wr_ok && reg_addr == ESC_REG_IRQ_STAT) ? reg_wdata[3:0] : 4'h0;

  // Sticky status, set wins over clear, and mask
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      stat_reg <= '0;
      mask_reg <= ESC_MASK_RST;
      irq <= 1'b0;
    end
    else
    begin
      stat_reg <= (stat_reg & ~stat_clr) | stat_set;
      if (wr_ok && reg_addr == ESC_REG_IRQ_MASK)
        mask_reg <= reg_wdata[3:0];
      irq <= |(stat_reg & mask_reg);
    end
  end

  // Read selection
  always_comb
  begin
    case (reg_addr)
      ESC_REG_CTRL: rd_mux = {14'h0000, ctl_reg};
      ESC_REG_STATUS: rd_mux = {11'h000, mark_ok_reg, self_en_reg, precise_run_reg, ramp_go, ready};
      ESC_REG_IRQ_STAT: rd_mux = {12'h000, stat_reg};
      ESC_REG_IRQ_MASK: rd_mux = {12'h000, mask_reg};
      ESC_REG_VOUT: rd_mux = vout_reg;
      ESC_REG_LIMIT: rd_mux = output_upper_limit;
      ESC_REG_BUS_ID: rd_mux = {9'h000, bus_id};
      ESC_REG_FSW: rd_mux = fsw_reg;
      ESC_REG_DUTY_MAX: rd_mux = {6'h00, duty_max_reg};
      ESC_REG_THRESH: rd_mux = thresh_reg;
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data for one cycle, zero while busy
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= '0;
      cfg_ready <= 1'b0;
      vout_set <= '0;
    end
    else
    begin
      reg_rdata <= (reg_rd && ready) ? rd_mux : 16'h0000;
      cfg_ready <= ready;
      vout_set <= vout_reg;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_ready_gate: assert property (sq_st_reg == SQ_OFF && !ready |=> sq_st_reg == SQ_OFF)
    else $error("ramp started without ready");
  a_pre_length: assert property ($rose(ramp_go) |-> $past(sq_cnt_reg) == ($past(precise_run_reg) ? PRE_P_END : PRE_N_END))
    else $error("pre-ramp delay wrong length");
  a_precise_pin: assert property ($rose(precise_run_reg) |-> $past(pin_reg[14]) && !$past(ctl_reg[ESC_CTRL_BUS_ON]))
    else $error("precise mode without pin enable");
  a_precise_self: assert property (precise_run_reg && sq_st_reg == SQ_PRE |-> !self_en_reg)
    else $error("precise mode on self-enabled device");
  a_duty_cap: assert property (duty_out <= 10'(ESC_DUTY_CAP) && (ramp_go || duty_out == 10'h000))
    else $error("duty above cap");
  a_strap_once: assert property (!$stable(bus_id) |-> $past(ld_st_reg) == LD_PINS)
    else $error("strap sampled outside load");
  a_limit_pct: assert property (ready |-> 32'(output_upper_limit) * 10 == 32'(pin_mv_reg) * 11)
    else $error("output limit not plus ten percent");
  a_busy_ignore: assert property (!ready && reg_wr |=> $stable(fsw_reg) && $stable(mask_reg) && $stable(vout_reg))
    else $error("bus write taken while busy");
  a_alert_set: assert property (ready && mon_value > thresh_reg |=> stat_reg[ESC_IRQ_ALERT] ##1
    (irq || !$past(mask_reg[ESC_IRQ_ALERT])))
    else $error("alert not raised");
endmodule
`default_nettype wire

// [verif/esc_host_model.sv]
// Host-side model that drives the turn-on pin
`timescale 1ns/1ps
`default_nettype none
module esc_host_model #(
  parameter int GAP_CYC = 240
)(
  input wire logic ref_clk,
  input wire logic want_on,
  output logic en_pin
);
  // Cycles left before a new rise is allowed
  int gap = 0;
  // Pin moves only on clock edges; a rise waits out the re-enable gap
  always @(posedge ref_clk)
  begin
    if (!want_on)
    begin
      // Off delay, fall time and margin start at the drop
      if (en_pin)
        gap <= GAP_CYC;
      else if (gap > 0)
        gap <= gap - 1;
      en_pin <= 1'b0;
    end
    else if (gap == 0)
      en_pin <= 1'b1;
    else
      gap <= gap - 1;
  end
endmodule
`default_nettype wire

// [verif/esc_top_tb.sv]
// Self-checking testbench for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module esc_top_tb
  import esc_pkg::*;
;
  // Shortened counts
  localparam int PP = 20;
  localparam int PN = 40;
  localparam int OFN = 40;
  localparam int MC = 30;
  // Host re-enable gap in cycles
  localparam int GAP = 240;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic want_on = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] mon_value = 16'h0000;
  logic [15:0] reg_rdata, rv, v, vout_set, output_upper_limit;
  logic [6:0] bus_id_strap_pin, output_level_strap, bus_id, old;
  logic [9:0] duty_req = 10'h000;
  logic [9:0] duty_out, dm, d;
  logic en_pin, ramp_go, cfg_ready, irq;
  int num_errors = 0;
  int comparisons = 0;
  int n, f;
  int ftab [0:2] = '{200, 334, 1000};

  // Clock, 50 ns period
  always #25 ref_clk = ~ref_clk;

  esc_top #(.PRE_PRECISE_CYC(PP), .PRE_NORMAL_CYC(PN), .OFF_NORMAL_CYC(OFN), .MEMCHK_CYC(MC)) dut (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .en_pin(en_pin), .bus_id_strap_pin(bus_id_strap_pin),
    .output_level_strap(output_level_strap), .mon_value(mon_value), .duty_req(duty_req),
    .duty_out(duty_out), .ramp_go(ramp_go), .cfg_ready(cfg_ready), .bus_id(bus_id),
    .output_upper_limit(output_upper_limit), .vout_set(vout_set), .irq(irq));

  esc_host_model #(.GAP_CYC(GAP)) host (.ref_clk(ref_clk), .want_on(want_on), .en_pin(en_pin));

  // Verdict and end of run
  task automatic conclude;
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Value compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Cycle count compare against a window
  task automatic chk_win(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi)
    begin
      num_errors++;
      $display("MISMATCH %0t %s took %0d cycles", $time, what, got);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [15:0] dat);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle register read, data taken the cycle after
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  // Bounded wait for ramp_go (sel 0) or cfg_ready (sel 1)
  task automatic wait_for(input int sel, input logic lvl, output int cyc);
    cyc = 0;
    while ((sel ? cfg_ready : ramp_go) !== lvl)
    begin
      @(posedge ref_clk);
      #1;
      cyc++;
      if (cyc > 400)
      begin
        num_errors++;
        $display("MISMATCH %0t wait ran out", $time);
        conclude();
      end
    end
  endtask

  // Poll status until the loader reports ready
  task automatic wait_ready;
    int i;
    for (i = 0; i < 200; i++)
    begin
      rd(ESC_REG_STATUS);
      if (rv[0] === 1'b1)
        return;
    end
    num_errors++;
    $display("MISMATCH %0t loader never ready", $time);
    conclude();
  endtask

  // Random strap code, resistor index kept in range
  function automatic logic [6:0] rnd_strap();
    return {2'($urandom % 4), 5'($urandom % 31)};
  endfunction

  // Strap code to millivolts
  function automatic logic [15:0] exp_mv(input logic [6:0] s);
    case (s[6:5])
      2'h0: return ESC_LOW_MV;
      2'h1: return ESC_OPEN_MV;
      2'h2: return ESC_HIGH_MV;
      default: return ESC_RES_MV[s[4:0]];
    endcase
  endfunction

  // Strap code to bus address
  function automatic logic [6:0] exp_id(input logic [6:0] s);
    return 7'(ESC_BUS_ID_BASE + ((s[6:5] == 2'h3) ? 7'h03 + s[4:0] : 7'(s[6:5])));
  endfunction

  // Duty ceiling from switching frequency in kHz
  function automatic logic [9:0] exp_dm(input int fk);
    int m;
    m = 1000 - (fk * 150 + 999) / 1000;
    return 10'((m > 950) ? 950 : m);
  endfunction

  // Main sequence
  initial
  begin
    void'($urandom(85));
    bus_id_strap_pin <= rnd_strap();
    output_level_strap <= rnd_strap();
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    // Traffic during the memory check is ignored
    rd(ESC_REG_STATUS);
    chk(rv, 16'h0000, "busy read");
    wr(ESC_REG_VOUT, 16'h1234);
    wait_for(1, 1'b1, n);
    chk(16'(bus_id), 16'(exp_id(bus_id_strap_pin)), "bus id");
    chk(output_upper_limit, 16'(exp_mv(output_level_strap) * 11 / 10), "limit");
    chk(vout_set, exp_mv(output_level_strap), "vout");
    chk(16'(irq), 16'h0000, "masked irq");
    rd(ESC_REG_CTRL);
    chk(rv, 16'h0002, "ctrl reset");
    // Pin-only values resist writes, vout reads back
    wr(ESC_REG_LIMIT, 16'hFFFF);
    wr(ESC_REG_BUS_ID, 16'h007F);
    rd(ESC_REG_LIMIT);
    chk(rv, 16'(exp_mv(output_level_strap) * 11 / 10), "limit ro");
    rd(ESC_REG_BUS_ID);
    chk(rv, 16'(exp_id(bus_id_strap_pin)), "id ro");
    v = 16'($urandom % 5000);
    wr(ESC_REG_VOUT, v);
    rd(ESC_REG_VOUT);
    chk(rv, v, "vout rw");
    // Duty ceiling over corner and random frequencies
    for (n = 0; n < 4; n++)
    begin
      f = (n < 3) ? ftab[n] : 200 + $urandom % 801;
      wr(ESC_REG_FSW, 16'(f));
      rd(ESC_REG_DUTY_MAX);
      chk(rv, 16'(exp_dm(f)), "duty max");
    end
    dm = exp_dm(f);
    // Bus enable uses normal timing even with precise selected
    wr(ESC_REG_IRQ_MASK, 16'h0002);
    wr(ESC_REG_CTRL, 16'h0003);
    wait_for(0, 1'b1, n);
    chk_win(n, PN - 1, PN + 3, "bus enable");
    repeat (2) @(posedge ref_clk);
    #1 chk(16'(irq), 16'h0001, "ramp irq");
    for (n = 0; n < 9; n++)
    begin
      d = (n == 0) ? dm : (n == 1) ? dm + 10'h001 : (n == 2) ? 10'h3E8 : 10'($urandom % 1001);
      @(posedge ref_clk);
      duty_req <= d;
      repeat (2) @(posedge ref_clk);
      #1 chk(16'(duty_out), 16'((d > dm) ? dm : d), "duty clamp");
    end
    wr(ESC_REG_IRQ_STAT, 16'h000F);
    repeat (2) @(posedge ref_clk);
    #1 chk(16'(irq), 16'h0000, "irq cleared");
    wr(ESC_REG_CTRL, 16'h0002);
    wait_for(0, 1'b0, n);
    chk_win(n, OFN - 1, OFN + 3, "normal off");
    chk(16'(duty_out), 16'h0000, "duty off");
    // Pin enable runs precise timing
    @(posedge ref_clk);
    want_on <= 1'b1;
    wait_for(0, 1'b1, n);
    chk_win(n, PP, PP + 7, "pin enable");
    rd(ESC_REG_STATUS);
    chk(16'(rv[2]), 16'h0001, "precise run");
    want_on <= 1'b0;
    wait_for(0, 1'b0, n);
    chk_win(n, 1, 9, "precise off");
    // Alert from a preset threshold
    wr(ESC_REG_THRESH, 16'h0100);
    mon_value <= 16'h0200;
    wr(ESC_REG_IRQ_MASK, 16'h0008);
    repeat (2) @(posedge ref_clk);
    #1 chk(16'(irq), 16'h0001, "alert irq");
    mon_value <= 16'h0000;
    wr(ESC_REG_IRQ_STAT, 16'h000F);
    rd(ESC_REG_IRQ_STAT);
    chk(16'(rv[3]), 16'h0000, "alert clear");
    // Save, change straps, then restore
    v = 16'($urandom % 5000);
    wr(ESC_REG_VOUT, v);
    wr(ESC_REG_CTRL, 16'h000A);
    wait_ready();
    old = bus_id_strap_pin;
    bus_id_strap_pin <= rnd_strap();
    output_level_strap <= rnd_strap();
    repeat (8) @(posedge ref_clk);
    #1 chk(16'(bus_id), 16'(exp_id(old)), "no resample");
    wr(ESC_REG_CTRL, 16'h0006);
    wait_ready();
    chk(16'(bus_id), 16'(exp_id(bus_id_strap_pin)), "resampled id");
    chk(output_upper_limit, 16'(exp_mv(output_level_strap) * 11 / 10), "new limit");
    chk(vout_set, v, "stored vout");
    // Pin high at power-up gives a self-enabled part on normal timing
    repeat (GAP) @(posedge ref_clk);
    @(posedge ref_clk);
    want_on <= 1'b1;
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    wait_for(1, 1'b1, n);
    wait_for(0, 1'b1, n);
    chk_win(n, PN - 3, PN + 3, "self enable");
    rd(ESC_REG_STATUS);
    chk(16'(rv[3]), 16'h0001, "self flag");
    conclude();
  end
endmodule
`default_nettype wire
